// ===== hw/fdc_top.sv
// Fractional divider control, coarse trim sequencer and dual lock detector.
//
// Summary of operation
// - One select bit each reference period.
// - Two 5-bit counts come from serial word.
// - Zero count forces stream constant.
// - Pattern length is sum of counts.
// - Accumulator adds minus-one count modulo sum.
// - Bit is zero when modulo alters sum.
// - Sequence repeats when accumulator returns zero.
// - Coarse trim is 8-bit stepped counter.
// - Trim against first loop, shared both oscillators.
// - Lock output high only when both locked.
// - At most one error pulse per edge.
// - Lock after 256 clean clocks, large errors restart.
// - Locked loop up/down counts to 256 net.
// - Denominator select decodes to fixed divisors.
// - Bits shift on serial clock while selected.
// - Select falling edge starts new acquisition.
`timescale 1ns/1ps
`include "fdc_map.svh"
module fdc_top (
   // System clock (reference clock domain), reset and enable.
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       clk_en,
   // Serial configuration link; serial_clock clocks the shift register.
   input  wire logic       serial_clock,
   input  wire logic       serial_select,
   input  wire logic       serial_data_in,
   // Analog-facing status inputs, asynchronous to clk_sys.
   input  wire logic       trim_centre_reached,
   input  wire logic       large_error_first,
   input  wire logic       small_error_first,
   input  wire logic       large_error_second,
   input  wire logic       small_error_second,
   // Outputs.
   output logic            modulus_select_bit,
   output logic [7:0]      coarse_trim,
   output logic            trim_done,
   output logic            locked,
   output logic [5:0]      denominator_divisor,
   output fdc_pkg::fdc_cfg_t config_word
);
   // ****************************************************
   // Serial link domain
   // ****************************************************
   logic [31:0] shift_r;

   // Shift one bit per rising serial clock while selected.
   // Nothing here is cleared by start, so a re-trigger reuses the last word.
   // serial capture
   always_ff @(posedge serial_clock or posedge rst) begin
      if (rst) begin
         shift_r <= 32'h0000_0000;
      end else if (serial_select) begin
         shift_r <= {shift_r[30:0], serial_data_in};
      end
   end

   // ****************************************************
   // Synchronisers and start detection
   // ****************************************************
   logic [1:0] sel_s_r;
   logic       sel_d_r;
   logic [1:0] cen_s_r;
   logic [1:0] le1_s_r, se1_s_r, le2_s_r, se2_s_r;
   logic       start;
   logic       centre;
   logic       le1, se1, le2, se2;

   // Two stages on each asynchronous input; second stage alone is used.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sel_s_r <= 2'h0;
         sel_d_r <= 1'b0;
         cen_s_r <= 2'h0;
         le1_s_r <= 2'h0;
         se1_s_r <= 2'h0;
         le2_s_r <= 2'h0;
         se2_s_r <= 2'h0;
      end else if (clk_en) begin
         sel_s_r <= {sel_s_r[0], serial_select};
         sel_d_r <= sel_s_r[1];
         cen_s_r <= {cen_s_r[0], trim_centre_reached};
         le1_s_r <= {le1_s_r[0], large_error_first};
         se1_s_r <= {se1_s_r[0], small_error_first};
         le2_s_r <= {le2_s_r[0], large_error_second};
         se2_s_r <= {se2_s_r[0], small_error_second};
      end
   end
   assign start  = sel_d_r & ~sel_s_r[1] & clk_en;
   assign centre = cen_s_r[1];
   assign le1 = le1_s_r[1];
   assign se1 = se1_s_r[1];
   assign le2 = le2_s_r[1];
   assign se2 = se2_s_r[1];

   // The shift register is static once select has fallen and been
   // synchronised, so capturing the word here is a safe handshake.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         config_word <= '0;
      end else if (start) begin
         config_word <= fdc_pkg::fdc_cfg_t'({shift_r[`FDC_QP_MSB -: 5],
                        shift_r[`FDC_COUNT_DIVIDE_BY_MODULUS_MINUS_ONE_MSB -: 5], shift_r[`FDC_MODSEL_MSB -: 4],
                        shift_r[`FDC_POSTDIV_MSB -: 5], shift_r[`FDC_NSEL_MSB -: 3],
                        shift_r[`FDC_MSEL_MSB -: 3]});
      end
   end

   // ****************************************************
   // Pattern generator
   // ****************************************************
   logic [4:0] acc_r;
   logic [5:0] sum;
   logic [5:0] period;
   logic       wrap;

   assign period = {1'b0, config_word.count_divide_by_modulus}
                 + {1'b0, config_word.count_divide_by_modulus_minus_one};
   assign sum    = {1'b0, acc_r} + {1'b0, config_word.count_divide_by_modulus_minus_one};
   assign wrap   = (sum >= period);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_r              <= 5'h00;
         modulus_select_bit <= 1'b0;
      end else if (clk_en) begin
         if (start) begin
            acc_r              <= 5'h00;
            modulus_select_bit <= 1'b0;
         end else begin
            acc_r              <= wrap ? 5'(sum - period) : sum[4:0];
            modulus_select_bit <= ~wrap;
         end
      end
   end

   // ****************************************************
   // Acquisition sequencer
   // ****************************************************
   fdc_pkg::fdc_acq_t state_r;

   // step trim until centre or 8'hff, then hold
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r     <= fdc_pkg::FDC_IDLE;
         coarse_trim <= `FDC_TRIM_RESET;
      end else if (clk_en) begin
         if (start) begin
            state_r     <= fdc_pkg::FDC_TRIM;
            coarse_trim <= `FDC_TRIM_RESET;
         end else begin
            unique case (state_r)
               fdc_pkg::FDC_IDLE: begin
               end
               fdc_pkg::FDC_TRIM: begin
                  if (centre || coarse_trim == 8'hff) begin
                     state_r <= fdc_pkg::FDC_TRACK;
                  end else begin
                     coarse_trim <= coarse_trim + 8'h01;
                  end
               end
               fdc_pkg::FDC_TRACK: begin
               end
               default: state_r <= fdc_pkg::FDC_IDLE;
            endcase
         end
      end
   end
   assign trim_done = (state_r == fdc_pkg::FDC_TRACK);

   // ****************************************************
   // Lock detectors, one per loop
   // ****************************************************
   logic [1:0] lk_r;
   logic [8:0] cnt_r [2];
   logic [1:0] le_v, se_v;
   assign le_v = {le2, le1};
   assign se_v = {se2, se1};

   // Each loop counts clean clocks when unlocked, net errors when locked.
   for (genvar g = 0; g < 2; g++) begin : g_lock
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            lk_r[g]  <= 1'b0;
            cnt_r[g] <= 9'h000;
         end else if (clk_en) begin
            if (start || !trim_done) begin
               lk_r[g]  <= 1'b0;
               cnt_r[g] <= 9'h000;
            end else if (!lk_r[g]) begin
               if (le_v[g]) begin
                  cnt_r[g] <= 9'h000;
               end else if (cnt_r[g] == `FDC_LOCK_COUNT - 9'd1) begin
                  lk_r[g]  <= 1'b1;
                  cnt_r[g] <= 9'h000;
               end else begin
                  cnt_r[g] <= cnt_r[g] + 9'h001;
               end
            end else begin
               if (le_v[g] && !se_v[g]) begin
                  if (cnt_r[g] == `FDC_LOCK_COUNT - 9'd1) begin
                     lk_r[g]  <= 1'b0;
                     cnt_r[g] <= 9'h000;
                  end else begin
                     cnt_r[g] <= cnt_r[g] + 9'h001;
                  end
               end else if (se_v[g] && !le_v[g] && cnt_r[g] != 9'h000) begin
                  cnt_r[g] <= cnt_r[g] - 9'h001;
               end
            end
         end
      end
   end
   assign locked = lk_r[0] & lk_r[1];

   // ****************************************************
   // Denominator decode
   // ****************************************************
   // denominator table
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         denominator_divisor <= `FDC_DENOM_RESET;
      end else if (clk_en) begin
         unique case (config_word.wrapper_denominator_select)
            3'b000: denominator_divisor <= 6'd16;
            3'b001: denominator_divisor <= 6'd16;
            3'b010: denominator_divisor <= 6'd18;
            3'b011: denominator_divisor <= 6'd17;
            3'b100: denominator_divisor <= 6'd31;
            3'b101: denominator_divisor <= 6'd14;
            3'b110: denominator_divisor <= 6'd32;
            3'b111: denominator_divisor <= 6'd15;
         endcase
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   // Lock-count and trim checks exclude start cycles, since start overrides every branch.
   a_lock_both: assert property (@(posedge clk_sys) disable iff (rst)
      locked |-> (trim_done && lk_r[0] && lk_r[1]))
      else $error("lock without both loops");
   a_start_clears: assert property (@(posedge clk_sys) disable iff (rst)
      start |=> (!locked && acc_r == 5'h00 && coarse_trim == 8'h00))
      else $error("start did not clear state");
   a_bit_wrap: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !start) |=> (modulus_select_bit == !$past(wrap)))
      else $error("select bit wrong");
   a_acc_range: assert property (@(posedge clk_sys) disable iff (rst)
      (period != 6'd0) |-> ({1'b0, acc_r} < period || acc_r == 5'h00))
      else $error("accumulator out of range");
   a_trim_hold: assert property (@(posedge clk_sys) disable iff (rst)
      (trim_done && !start) |=> $stable(coarse_trim)) else $error("trim moved");
   a_lock_err: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !lk_r[0] && le1) |=> !lk_r[0]) else $error("locked despite error");
   a_lock_err_two: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !lk_r[1] && le2) |=> !lk_r[1])
      else $error("second loop locked despite error");
   a_lock_count: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !start && trim_done && !lk_r[0] && !le1
       && cnt_r[0] == `FDC_LOCK_COUNT - 9'd1) |=> lk_r[0]) else $error("lock not declared");
   a_unlock_cnt: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !start && trim_done && lk_r[0] && le1 && !se1
       && cnt_r[0] == `FDC_LOCK_COUNT - 9'd1) |=> !lk_r[0])
      else $error("net error count did not unlock");
   a_trim_step: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !start && state_r == fdc_pkg::FDC_TRIM && !centre && coarse_trim != 8'hff)
      |=> (coarse_trim == $past(coarse_trim) + 8'h01)) else $error("trim did not step");
   a_trim_stop: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !start && state_r == fdc_pkg::FDC_TRIM && (centre || coarse_trim == 8'hff))
      |=> trim_done) else $error("trim search did not stop");
   a_denom_dec: assert property (@(posedge clk_sys) disable iff (rst)
      (config_word.wrapper_denominator_select == 3'b100 && clk_en)
      |=> (denominator_divisor == 6'd31 || $changed(config_word)))
      else $error("denominator decode wrong");
endmodule

// ===== hw/fdc_map.svh
// Constants for the fractional divider control and lock block.
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH
`define FDC_WORD_BITS      32
`define FDC_QP_MSB         27
`define FDC_COUNT_DIVIDE_BY_MODULUS_MINUS_ONE_MSB       22
`define FDC_MODSEL_MSB     17
`define FDC_POSTDIV_MSB    10
`define FDC_NSEL_MSB       5
`define FDC_MSEL_MSB       2
`define FDC_LOCK_COUNT     9'd256
`define FDC_TRIM_RESET     8'h00
`define FDC_DENOM_RESET    6'd16
`endif

// ===== hw/fdc_pkg.sv
// Types shared by the fractional divider control block.
package fdc_pkg;
   typedef struct packed {
      logic [4:0] count_divide_by_modulus;
      logic [4:0] count_divide_by_modulus_minus_one;
      logic [3:0] modulus_select;
      logic [4:0] output_post_divider_select;
      logic [2:0] wrapper_numerator_select;
      logic [2:0] wrapper_denominator_select;
   } fdc_cfg_t;
   typedef enum logic [1:0] {
      FDC_IDLE  = 2'b00,
      FDC_TRIM  = 2'b01,
      FDC_TRACK = 2'b10
   } fdc_acq_t;
endpackage

// ===== tb/fdc_host.sv
// Host model that drives the three-wire serial configuration link.
`timescale 1ns/1ps
module fdc_host (
   // Serial link lines toward the device.
   output logic serial_clock,
   output logic serial_select,
   output logic serial_data_in
);
   // The link clock idles low outside frames.
   initial begin
      serial_clock   = 1'b0;
      serial_select  = 1'b0;
      serial_data_in = 1'b0;
   end
   // frame shifting MSB first
   // Sends the top n bits of w; with sel low the bits must be ignored.
   task automatic send_word(input logic [31:0] w, input logic sel, input int n);
      #7 serial_select = sel;
      for (int b = 31; b > 31 - n; b--) begin
         serial_data_in = w[b];
         #15 serial_clock = 1'b1;
         #15 serial_clock = 1'b0;
      end
      // Select stays up over two reference clocks so even an empty frame is seen.
      #45 serial_select = 1'b0;
      // A released data line must not keep looking valid.
      serial_data_in = ~serial_data_in;
      // The low time lets the synchroniser register the falling edge.
      #60;
   endtask
endmodule

// ===== tb/fdc_top_bench.sv
// Self-checking bench for the fractional divider control block.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin n_checks++; if ((sn) !== (ex)) begin err_total++; \
 $display("ERROR %s expected %0h seen %0h", nm, ex, sn); end end
module fdc_top_bench;
   // ****************************************
   // Stimulus, observed outputs and tables.
   // ****************************************
   logic              clk_sys = 1'b0;
   logic              rst = 1'b1;
   logic              centre = 1'b0;
   logic [3:0]        err_in = 4'h0; // Large1, small1, large2, small2.
   logic              sck, ssel, sdi, msb, tdone, locked;
   logic [7:0]        trim, t0;
   logic [5:0]        div;
   fdc_pkg::fdc_cfg_t cfg_out, exp_cfg;
   int                err_total = 0;
   int                n_checks = 0;
   int                k;
   // counts and sums within 31, never both zero
   logic [4:0] qtab [8] = '{5'h12, 5'h00, 5'h09, 5'h01, 5'h02, 5'h1f, 5'h00, 5'h0f};
   logic [4:0] mtab [8] = '{5'h05, 5'h07, 5'h00, 5'h01, 5'h01, 5'h00, 5'h1f, 5'h10};
   logic [5:0] dtab [8] = '{6'h10, 6'h10, 6'h12, 6'h11, 6'h1f, 6'h0e, 6'h20, 6'h0f};
   always #10 clk_sys = ~clk_sys;
   fdc_top fdc_top_i (
      .clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
      .serial_clock(sck), .serial_select(ssel), .serial_data_in(sdi),
      .trim_centre_reached(centre), .large_error_first(err_in[3]),
      .small_error_first(err_in[2]), .large_error_second(err_in[1]),
      .small_error_second(err_in[0]), .modulus_select_bit(msb), .coarse_trim(trim),
      .trim_done(tdone), .locked(locked), .denominator_divisor(div), .config_word(cfg_out));
   fdc_host fdc_host_i (.serial_clock(sck), .serial_select(ssel), .serial_data_in(sdi));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Error inputs change only by non-blocking assignment at the clock edge.
   task automatic hold_err(input logic [3:0] v, input int n);
      @(posedge clk_sys) err_in <= v;
      repeat (n) @(posedge clk_sys);
      err_in <= 4'h0;
      #1;
   endtask
   // The select stream is predicted by a reference accumulator over two periods.
   task automatic load_check(input logic [4:0] qp, input logic [4:0] qm, input logic [2:0] ms);
      int acc, sum, j;
      exp_cfg = {qp, qm, 4'h7, 5'h04, 3'h5, ms};
      fdc_host_i.send_word({4'h0, exp_cfg[24:11], 3'h0, exp_cfg[10:0]}, 1'b1, 32);
      for (j = 0; j < 20 && cfg_out !== exp_cfg; j++) cyc(1);
      `CHK("config_word", exp_cfg, cfg_out)
      acc = 0;
      sum = qp + qm;
      for (j = 0; j < 2 * sum; j++) begin
         cyc(1);
         `CHK("select_bit", (acc + qm < sum), msb)
         acc = (acc + qm) % sum;
      end
      `CHK("divisor", dtab[ms], div)
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // A hang beyond several times the expected run counts as a mismatch.
   initial begin
      #400000;
      err_total++;
      final_report();
   end
   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      cyc(1);
      `CHK("div_rst", 6'h10, div)
      `CHK("locked_rst", 1'b0, locked)
      for (int i = 0; i < 8; i++) load_check(qtab[i], mtab[i], i[2:0]);
      fdc_host_i.send_word(32'hffffffff, 1'b0, 32);
      fdc_host_i.send_word(32'h0, 1'b1, 0);
      cyc(8);
      `CHK("cfg_kept", exp_cfg, cfg_out)
      `CHK("trim_restart", 1'b1, trim < 8'h10)
      cyc(30);
      @(posedge clk_sys) centre <= 1'b1;
      cyc(8);
      t0 = trim;
      `CHK("trim_done", 1'b1, tdone)
      `CHK("trim_steps", 1'b1, t0 > 8'h1f && t0 < 8'h31)
      @(posedge clk_sys) centre <= 1'b0;
      cyc(100);
      `CHK("trim_hold", t0, trim)
      hold_err(4'h8, 1);
      for (k = 1; k < 400 && locked !== 1'b1; k++) cyc(1);
      `CHK("lock_delay", 1'b1, k > 254 && k < 266)
      hold_err(4'h2, 250);
      cyc(4);
      `CHK("lock_kept", 1'b1, locked)
      hold_err(4'h1, 10);
      hold_err(4'h2, 20);
      cyc(4);
      `CHK("unlocked", 1'b0, locked)
      for (k = 1; k < 400 && locked !== 1'b1; k++) cyc(1);
      `CHK("relocked", 1'b1, locked)
      fdc_host_i.send_word(32'h0, 1'b1, 0);
      cyc(6);
      `CHK("lock_cleared", 1'b0, locked)
      `CHK("cfg_reused", exp_cfg, cfg_out)
      final_report();
   end
endmodule
